// file: verilog/frequency_protection_element.sv
// one frequency protection element with APB register access
// assumes per-phase frequency in mHz, magnitudes and zero-crossing strobes from the front end
//
// How it works
// - mode register selects one of five modes; the other three codes never pick up
// - underfrequency alarm the cycle after a sample below is stored
// - underfrequency trip after full delay below threshold
// - overfrequency alarm immediately above threshold
// - overfrequency trip when above until delay expires
// - all voltages low blocks frequency, alarms, trips
// - hold blocking 0.5 s, frequency zero 0.3 s
// - any phase picks up when enabled and not externally or low-voltage blocked
// - frequency updated at each zero crossing
// - gradient recomputed at each zero crossing
// - gradient window 2 to 10 periods
// - gradient uses frequency averaged over the stabilizer window
// - own frequency stabilizer feeds gradient, default 3
// - gradient stabilizer window counted in cycles
// - gradient positive rising, negative falling
// - polarity positive, negative or absolute
// - gradient mode alarms when past threshold
// - gradient mode trips if still past after delay
// - combined modes need both conditions same phase
// - combined trip needs both still at expiry
// - combined set has thresholds, polarity, delay
`timescale 1ns/10ps

module frequency_protection_element #(
  parameter int unsigned MS_CYCLES = freq_prot_pkg::MS_CYCLES,
  parameter int unsigned NOM_FREQ_HZ = freq_prot_pkg::NOM_FREQ_HZ
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire freq_prot_pkg::apb_req_s apb_req,
  output freq_prot_pkg::apb_rsp_s apb_rsp,
  input wire freq_prot_pkg::phase_in_s phase_in,
  output logic alarm,
  output logic trip
);

  // ===========================================================================
  // state
  typedef struct packed {
    logic [11:0] ctrl;
    logic [15:0] freq_thr;
    logic [15:0] grad_thr;
    logic [15:0] delay_ms;
    logic [15:0] vblock;
    logic [11:0] window;
    logic [2:0][15:0][15:0] fhist;
    logic [2:0][4:0] fill;
    logic [2:0][7:0][15:0] ghist;
    logic [2:0][3:0] gfill;
    logic [2:0][15:0] grad;
    logic [23:0] ms_div;
    logic [9:0] block_hold;
    logic [9:0] zero_hold;
    logic [16:0] timer;
    logic [2:0] phase_pick;
    logic alarm;
    logic trip;
    freq_prot_pkg::apb_rsp_s rsp;
  } state_s;

  state_s st;
  state_s next_st;

  // ===========================================================================
  // helpers
  function automatic logic [15:0] avg_f(input logic [15:0][15:0] h, input int unsigned start,
                                        input int unsigned cnt);
    logic [19:0] sum;
    sum = 20'h00000;
    for (int i = 0; i < 16; i++) begin
      if (i >= start && i < start + cnt) begin
        sum = sum + {4'h0, h[i]};
      end
    end
    return 16'(sum / 20'(cnt));
  endfunction

  function automatic logic signed [15:0] avg_g(input logic [7:0][15:0] h, input int unsigned cnt);
    logic signed [19:0] sum;
    sum = 20'sh00000;
    for (int i = 0; i < 8; i++) begin
      if (i < cnt) begin
        sum = sum + 20'(signed'(h[i]));
      end
    end
    return 16'(sum / signed'(20'(cnt)));
  endfunction

  // ===========================================================================
  // configuration decode
  freq_prot_pkg::mode_e mode;
  freq_prot_pkg::pol_e pol;
  logic [3:0] gwin;
  logic [3:0] fstab;
  logic [3:0] gstab;
  logic all_low;
  logic blocked;
  logic freq_zero;
  logic ms_tick;
  logic [2:0] phase_cond;
  logic pickup;

  always_comb begin
    mode = freq_prot_pkg::mode_e'(st.ctrl[freq_prot_pkg::CTRL_MODE_LSB +: 3]);
    pol = freq_prot_pkg::pol_e'(st.ctrl[freq_prot_pkg::CTRL_POL_LSB +: 2]);
    gwin = st.window[freq_prot_pkg::WIN_GRAD_LSB +: 4];
    if (gwin < freq_prot_pkg::GRAD_WIN_MIN) begin
      gwin = freq_prot_pkg::GRAD_WIN_MIN;
    end else if (gwin > freq_prot_pkg::GRAD_WIN_MAX) begin
      gwin = freq_prot_pkg::GRAD_WIN_MAX;
    end
    fstab = st.window[freq_prot_pkg::WIN_FSTAB_LSB +: 4];
    if (fstab == 4'h0) begin
      fstab = 4'h1;
    end else if (fstab > freq_prot_pkg::FSTAB_MAX) begin
      fstab = freq_prot_pkg::FSTAB_MAX;
    end
    gstab = st.window[freq_prot_pkg::WIN_GSTAB_LSB +: 4];
    if (gstab == 4'h0) begin
      gstab = 4'h1;
    end else if (gstab > freq_prot_pkg::GSTAB_MAX) begin
      gstab = freq_prot_pkg::GSTAB_MAX;
    end
  end

  // ===========================================================================
  // low-voltage blocking
  always_comb begin
    all_low = 1'b1;
    for (int p = 0; p < 3; p++) begin
      if (phase_in.vmag[p] >= st.vblock) begin
        all_low = 1'b0;
      end
    end
    // hold counters keep blocking and zero frequency after the voltages return
    blocked = all_low || st.block_hold != 10'h000;
    freq_zero = all_low || st.zero_hold != 10'h000;
    ms_tick = st.ms_div == 24'(MS_CYCLES - 1);
  end

  // ===========================================================================
  // per-phase pickup conditions
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      logic f_cond;
      logic g_cond;
      logic signed [15:0] g;
      always_comb begin
        g = signed'(st.grad[p]);
        if (mode == freq_prot_pkg::MODE_UNDER || mode == freq_prot_pkg::MODE_UNDER_GRAD) begin
          f_cond = st.fhist[p][0] < st.freq_thr;
        end else begin
          f_cond = st.fhist[p][0] > st.freq_thr;
        end
        case (pol)
          freq_prot_pkg::POL_POS: g_cond = g > signed'({1'b0, st.grad_thr[14:0]});
          freq_prot_pkg::POL_NEG: g_cond = g < -signed'({1'b0, st.grad_thr[14:0]});
          default: g_cond = g > signed'({1'b0, st.grad_thr[14:0]}) ||
                            g < -signed'({1'b0, st.grad_thr[14:0]});
        endcase
        case (mode)
          freq_prot_pkg::MODE_UNDER,
          freq_prot_pkg::MODE_OVER: phase_cond[p] = f_cond && st.fill[p] != 5'h00;
          freq_prot_pkg::MODE_GRAD: phase_cond[p] = g_cond;
          freq_prot_pkg::MODE_UNDER_GRAD,
          freq_prot_pkg::MODE_OVER_GRAD: begin
            phase_cond[p] = f_cond && g_cond && st.fill[p] != 5'h00;
          end
          default: phase_cond[p] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    pickup = |phase_cond && st.ctrl[freq_prot_pkg::CTRL_EN_BIT] &&
             !st.ctrl[freq_prot_pkg::CTRL_EXT_BLOCK_BIT] && !blocked;
  end

  // ===========================================================================
  // next state
  always_comb begin
    logic [15:0] fs_now;
    logic [15:0] fs_old;
    logic signed [31:0] delta;
    logic signed [31:0] graw;
    logic [7:0] roff;
    logic [31:0] rdata;
    logic hit;
    fs_now = 16'h0000;
    fs_old = 16'h0000;
    delta = 32'sh0;
    graw = 32'sh0;
    roff = apb_req.paddr;
    rdata = 32'h0000_0000;
    hit = 1'b1;
    next_st = st;

    // ms divider, shared by the hold timers and the tripping delay
    next_st.ms_div = ms_tick ? 24'h000000 : st.ms_div + 24'h000001;

    // blocking hold timers
    if (all_low) begin
      next_st.block_hold = 10'(freq_prot_pkg::BLOCK_HOLD_MS);
      next_st.zero_hold = 10'(freq_prot_pkg::ZERO_HOLD_MS);
    end else if (ms_tick) begin
      if (st.block_hold != 10'h000) begin
        next_st.block_hold = st.block_hold - 10'h001;
      end
      if (st.zero_hold != 10'h000) begin
        next_st.zero_hold = st.zero_hold - 10'h001;
      end
    end

    // frequency and gradient per phase
    for (int p = 0; p < 3; p++) begin
      // histories cleared so no stale sample survives a blocking spell
      if (blocked) begin
        next_st.fhist[p] = '0;
        next_st.fill[p] = 5'h00;
        next_st.ghist[p] = '0;
        next_st.gfill[p] = 4'h0;
        next_st.grad[p] = 16'h0000;
      end else if (phase_in.zero_cross[p]) begin
        next_st.fhist[p] = {st.fhist[p][14:0], phase_in.freq[p]};
        if (st.fill[p] != 5'h10) begin
          next_st.fill[p] = st.fill[p] + 5'h01;
        end
        if (32'(next_st.fill[p]) >= 32'(gwin) + 32'(fstab)) begin
          fs_now = avg_f(next_st.fhist[p], 0, 32'(fstab));
          fs_old = avg_f(next_st.fhist[p], 32'(gwin), 32'(fstab));
          delta = signed'(32'(fs_now)) - signed'(32'(fs_old));
          graw = (delta * signed'(32'(NOM_FREQ_HZ))) / signed'(32'(gwin));
          // saturate so the 16-bit history cannot wrap
          if (graw > 32'sd32767) begin
            graw = 32'sd32767;
          end else if (graw < -32'sd32767) begin
            graw = -32'sd32767;
          end
          next_st.ghist[p] = {st.ghist[p][6:0], graw[15:0]};
          if (st.gfill[p] != 4'h8) begin
            next_st.gfill[p] = st.gfill[p] + 4'h1;
          end
          if (next_st.gfill[p] >= gstab) begin
            next_st.grad[p] = 16'(avg_g(next_st.ghist[p], 32'(gstab)));
          end
        end
      end
    end

    // alarm and tripping delay
    next_st.alarm = pickup;
    next_st.phase_pick = phase_cond;
    // the first ms tick after pickup may be partial, so one extra tick is counted
    if (pickup) begin
      if (st.timer > {1'b0, st.delay_ms} || st.delay_ms == 16'h0000) begin
        next_st.trip = 1'b1;
      end else if (ms_tick) begin
        next_st.timer = st.timer + 17'h00001;
      end
    end else begin
      next_st.timer = 17'h00000;
      next_st.trip = 1'b0;
    end

    // APB slave, one wait state
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    next_st.rsp.prdata = 32'h0000_0000;
    // the pready guard keeps a held access from being taken twice
    if (apb_req.psel && apb_req.penable && !st.rsp.pready) begin
      if (roff == freq_prot_pkg::CTRL_OFS) begin
        rdata = {20'h00000, st.ctrl};
        if (apb_req.pwrite) begin
          next_st.ctrl = apb_req.pwdata[11:0];
        end
      end else if (roff == freq_prot_pkg::FREQ_THR_OFS) begin
        rdata = {16'h0000, st.freq_thr};
        if (apb_req.pwrite) begin
          next_st.freq_thr = apb_req.pwdata[15:0];
        end
      end else if (roff == freq_prot_pkg::GRAD_THR_OFS) begin
        rdata = {16'h0000, st.grad_thr};
        if (apb_req.pwrite) begin
          next_st.grad_thr = {1'b0, apb_req.pwdata[14:0]};
        end
      end else if (roff == freq_prot_pkg::DELAY_OFS) begin
        rdata = {16'h0000, st.delay_ms};
        if (apb_req.pwrite) begin
          next_st.delay_ms = apb_req.pwdata[15:0];
        end
      end else if (roff == freq_prot_pkg::VBLOCK_OFS) begin
        rdata = {16'h0000, st.vblock};
        if (apb_req.pwrite) begin
          next_st.vblock = apb_req.pwdata[15:0];
        end
      end else if (roff == freq_prot_pkg::WINDOW_OFS) begin
        rdata = {20'h00000, st.window};
        if (apb_req.pwrite) begin
          next_st.window = apb_req.pwdata[11:0];
        end
      end else if (roff == freq_prot_pkg::STATUS_OFS) begin
        rdata = {25'h0000000, st.phase_pick, freq_zero, blocked, st.trip, st.alarm};
      end else if (roff == freq_prot_pkg::FREQ_OFS) begin
        rdata = freq_zero ? 32'h0000_0000 : {16'h0000, st.fhist[0][0]};
      end else if (roff == freq_prot_pkg::GRAD_OFS) begin
        rdata = freq_zero ? 32'h0000_0000 : {{16{st.grad[0][15]}}, st.grad[0]};
      end else begin
        hit = 1'b0;
      end
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = !hit;
      next_st.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
    end
  end

  // ===========================================================================
  // registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.ctrl <= freq_prot_pkg::CTRL_RST;
      st.freq_thr <= freq_prot_pkg::FREQ_THR_RST;
      st.grad_thr <= freq_prot_pkg::GRAD_THR_RST;
      st.delay_ms <= freq_prot_pkg::DELAY_RST;
      st.vblock <= freq_prot_pkg::VBLOCK_RST;
      st.window <= {freq_prot_pkg::GSTAB_RST, freq_prot_pkg::FSTAB_RST,
                    freq_prot_pkg::GRAD_WIN_RST};
    end else begin
      st <= next_st;
    end
  end

  // ===========================================================================
  // outputs
  always_comb begin
    apb_rsp = st.rsp;
    alarm = st.alarm;
    trip = st.trip;
  end

endmodule

// file: include/freq_prot_pkg.sv
// constants, enumerations and carriers for the frequency protection element
// assumes a 10 MHz core clock and an APB master with 32-bit data
package freq_prot_pkg;
  // ===========================================================================
  // sizes
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned PHASES = 3;
  localparam int unsigned FHIST_D = 16;
  localparam int unsigned GHIST_D = 8;
  // ===========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FREQ_THR_OFS = 8'h04;
  localparam logic [7:0] GRAD_THR_OFS = 8'h08;
  localparam logic [7:0] DELAY_OFS = 8'h0C;
  localparam logic [7:0] VBLOCK_OFS = 8'h10;
  localparam logic [7:0] WINDOW_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] FREQ_OFS = 8'h1C;
  localparam logic [7:0] GRAD_OFS = 8'h20;
  // ===========================================================================
  // field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_EXT_BLOCK_BIT = 1;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_POL_LSB = 8;
  localparam int unsigned WIN_GRAD_LSB = 0;
  localparam int unsigned WIN_FSTAB_LSB = 4;
  localparam int unsigned WIN_GSTAB_LSB = 8;
  localparam int unsigned ST_ALARM_BIT = 0;
  localparam int unsigned ST_TRIP_BIT = 1;
  localparam int unsigned ST_BLOCK_BIT = 2;
  localparam int unsigned ST_FZERO_BIT = 3;
  localparam int unsigned ST_PHASE_LSB = 4;
  // ===========================================================================
  // reset values and limits
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [15:0] FREQ_THR_RST = 16'hC350;
  localparam logic [15:0] GRAD_THR_RST = 16'h03E8;
  localparam logic [15:0] DELAY_RST = 16'h0064;
  localparam logic [15:0] VBLOCK_RST = 16'h0000;
  localparam logic [3:0] GRAD_WIN_RST = 4'h2;
  localparam logic [3:0] FSTAB_RST = 4'h3;
  localparam logic [3:0] GSTAB_RST = 4'h1;
  localparam logic [3:0] GRAD_WIN_MIN = 4'h2;
  localparam logic [3:0] GRAD_WIN_MAX = 4'hA;
  localparam logic [3:0] FSTAB_MAX = 4'h6;
  localparam logic [3:0] GSTAB_MAX = 4'h8;
  // ===========================================================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned BLOCK_HOLD_MS = 500;
  localparam int unsigned ZERO_HOLD_MS = 300;
  localparam int unsigned NOM_FREQ_HZ = 50;
  // ===========================================================================
  // enumerations
  typedef enum logic [2:0] {
    MODE_UNDER, MODE_OVER, MODE_GRAD, MODE_UNDER_GRAD, MODE_OVER_GRAD,
    MODE_UNDER_DIFF, MODE_OVER_DIFF, MODE_SURGE
  } mode_e;
  typedef enum logic [1:0] {POL_POS, POL_NEG, POL_ABS} pol_e;
  // ===========================================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;
  typedef struct packed {
    logic [PHASES-1:0][FREQ_W-1:0] freq;
    logic [PHASES-1:0][FREQ_W-1:0] vmag;
    logic [PHASES-1:0] zero_cross;
  } phase_in_s;
endpackage

// file: dv/freq_prot_props.sv
// concurrent checks on the frequency protection element ports
// assumes bind onto the design top, one clock domain, APB writes snooped for settings
`timescale 1ns/10ps
module freq_prot_props #(
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire freq_prot_pkg::apb_req_s apb_req,
  input wire freq_prot_pkg::apb_rsp_s apb_rsp,
  input wire freq_prot_pkg::phase_in_s phase_in,
  input wire logic alarm,
  input wire logic trip
);
  // ==========================================================================
  // shadow of written settings
  logic [11:0] ctrl;
  logic [15:0] dly;
  logic [15:0] vblk;
  int unsigned acnt;
  logic wr;
  logic low;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && !apb_rsp.pready;
  assign low = (phase_in.vmag[0] < vblk) && (phase_in.vmag[1] < vblk)
    && (phase_in.vmag[2] < vblk);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= freq_prot_pkg::CTRL_RST;
      dly <= freq_prot_pkg::DELAY_RST;
      vblk <= freq_prot_pkg::VBLOCK_RST;
      acnt <= 0;
    end else begin
      if (wr && apb_req.paddr == freq_prot_pkg::CTRL_OFS) ctrl <= apb_req.pwdata[11:0];
      if (wr && apb_req.paddr == freq_prot_pkg::DELAY_OFS) dly <= apb_req.pwdata[15:0];
      if (wr && apb_req.paddr == freq_prot_pkg::VBLOCK_OFS) vblk <= apb_req.pwdata[15:0];
      acnt <= alarm ? acnt + 1 : 0;
    end
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence
  a_apb_one_wait: assert property (s_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("access not answered after one wait state");
  a_err_unmapped: assert property (s_access and apb_rsp.pready && apb_req.paddr > 8'h20
    |-> apb_rsp.pslverr) else $error("unmapped access without error");
  a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == '0)
    else $error("error response malformed");
  a_alarm_cause: assert property ($rose(alarm) |-> $past(ctrl[0]) && !$past(ctrl[1]))
    else $error("alarm while disabled or blocked");
  a_ext_quiet: assert property (ctrl[1] [*3] |-> !alarm && !trip)
    else $error("output while externally blocked");
  a_block_quiet: assert property (low [*4] |-> !alarm && !trip)
    else $error("output while voltages low");
  a_trip_alarm: assert property (trip |-> alarm)
    else $error("trip without alarm");
  a_drop_clear: assert property ($fell(alarm) |-> !trip ##1 !trip)
    else $error("trip after dropout");
  a_trip_delay: assert property ($rose(trip) |->
    dly == 0 || acnt >= dly * MS_CYCLES)
    else $error("trip before delay elapsed");
endmodule
bind frequency_protection_element freq_prot_props #(.MS_CYCLES(MS_CYCLES)) freq_prot_props_i (
  .core_clk(core_clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .phase_in(phase_in), .alarm(alarm), .trip(trip));

// file: dv/phase_source.sv
// voltage front end model: ramped per-phase frequency with zero-crossing strobes
// assumes commands from the bench on core_clk; frequency is only valid at a crossing
`timescale 1ns/10ps
module phase_source #(
  parameter int PERIOD = 20
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [15:0] f0,
  input wire logic [15:0] step,
  input wire logic [2:0] mask,
  input wire logic [15:0] vm,
  output freq_prot_pkg::phase_in_s ph
);
  logic [15:0] cur;
  int cnt;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      cur <= 16'hC350;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (load) cur <= f0;
      else if (cnt == PERIOD - 1) cur <= cur + step;
    end
  end
  // unmasked phases sit at nominal; between crossings the value is scrambled
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      ph.zero_cross[p] = (cnt == p * 5);
      ph.freq[p] = ph.zero_cross[p] ? (mask[p] ? cur : 16'hC350) : ~cur;
      ph.vmag[p] = vm;
    end
  end
endmodule

// file: dv/test_frequency_protection_element.sv
// self-checking bench for the frequency protection element
// assumes the bound checker and the phase_source front end model
`timescale 1ns/10ps
module test_frequency_protection_element;
  logic core_clk = 0;
  logic nrst = 0;
  freq_prot_pkg::apb_req_s req = '0;
  freq_prot_pkg::apb_rsp_s rsp;
  freq_prot_pkg::phase_in_s ph;
  logic alarm;
  logic trip;
  logic load = 0;
  logic [15:0] f0 = 16'hC350;
  logic [15:0] step = 16'h0;
  logic [2:0] mask = 3'h7;
  logic [15:0] vm = 16'h01F4;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int num_checks = 0;
  int unsigned seed = 55;
  initial forever #50 core_clk = ~core_clk;
  frequency_protection_element #(.MS_CYCLES(10)) frequency_protection_element_i (
    .core_clk(core_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .phase_in(ph), .alarm(alarm), .trip(trip));
  phase_source phase_source_i (.core_clk(core_clk), .nrst(nrst), .load(load), .f0(f0),
    .step(step), .mask(mask), .vm(vm), .ph(ph));
  // ==========================================================================
  // helpers
  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic pick(int mode, int pol, int f, int g, int thr);
    logic fu;
    logic fo;
    logic gp;
    fu = f < thr;
    fo = f > thr;
    gp = (pol == 0) ? g > 1000 : (pol == 1) ? g < -1000 : (g > 1000 || g < -1000);
    case (mode)
      0: return fu;
      1: return fo;
      2: return gp;
      3: return fu && gp;
      4: return fo && gp;
      default: return 1'b0;
    endcase
  endfunction
  function logic [31:0] cv(int mode, int pol, logic ext);
    return {22'h0, 2'(pol), 1'b0, 3'(mode), 2'b00, ext, 1'b1};
  endfunction
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: register %h, want %h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: output %b, want %b", $time, got, exp);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task apb(input logic wt, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, wt, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    chk_reg(32'(n), 32'h0000_0002);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask
  task ld(input int f, input int s, input logic [2:0] m);
    @(posedge core_clk);
    f0 <= 16'(f);
    step <= 16'(s);
    mask <= m;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
  endtask
  task run_case(input int mode, input int pol, input int f, input int gw);
    int s;
    int thr;
    logic [2:0] m;
    logic e;
    s = 30 + rnd() % 31;
    if (rnd() % 2) s = -s;
    m = 3'(rnd() % 7 + 1);
    thr = (mode == 1 || mode == 4) ? 51000 : 49000;
    e = pick(mode, pol, f, s * 50, thr);
    apb(1'b1, freq_prot_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, freq_prot_pkg::FREQ_THR_OFS, 32'(thr));
    apb(1'b1, freq_prot_pkg::WINDOW_OFS, 32'(32'h130 + gw));
    ld(f, s, m);
    w(300);
    apb(1'b1, freq_prot_pkg::CTRL_OFS, cv(mode, pol, 1'b0));
    w(300);
    chk_pin(alarm, e);
    chk_pin(trip, e);
    if (m[0]) begin
      apb(1'b0, freq_prot_pkg::GRAD_OFS, 32'h0);
      chk_reg(rd, 32'(s * 50));
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================================
  // sequence
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    final_report;
  end
  initial begin
    logic [31:0] rv [6];
    rv = '{32'h0, 32'hC350, 32'h3E8, 32'h64, 32'h0, 32'h132};
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), rv[i]);
    apb(1'b0, 8'h24, 32'h0);
    chk_pin(er, 1'b1);
    apb(1'b1, freq_prot_pkg::FREQ_THR_OFS, 32'(49000));
    apb(1'b1, freq_prot_pkg::DELAY_OFS, 32'h64);
    ld(47000, 0, 3'h7);
    apb(1'b1, freq_prot_pkg::CTRL_OFS, cv(0, 0, 1'b0));
    w(40);
    chk_pin(alarm, 1'b1);
    chk_pin(trip, 1'b0);
    ld(50000, 0, 3'h7);
    w(40);
    chk_pin(alarm, 1'b0);
    chk_pin(trip, 1'b0);
    apb(1'b1, freq_prot_pkg::CTRL_OFS, cv(0, 0, 1'b1));
    ld(47000, 0, 3'h7);
    w(40);
    chk_pin(alarm, 1'b0);
    apb(1'b1, freq_prot_pkg::CTRL_OFS, cv(0, 0, 1'b0));
    w(40);
    chk_pin(alarm, 1'b1);
    apb(1'b1, freq_prot_pkg::DELAY_OFS, 32'h3);
    for (int i = 0; i < 12; i++) run_case(i % 8, i % 3, (rnd() % 2) ? 47000 : 53000, i % 9 + 2);
    apb(1'b1, freq_prot_pkg::FREQ_THR_OFS, 32'(49000));
    apb(1'b1, freq_prot_pkg::VBLOCK_OFS, 32'h64);
    ld(47000, 0, 3'h7);
    vm <= 16'h0032;
    apb(1'b1, freq_prot_pkg::CTRL_OFS, cv(0, 0, 1'b0));
    w(100);
    chk_pin(alarm, 1'b0);
    rchk(freq_prot_pkg::FREQ_OFS, 32'h0);
    vm <= 16'h01F4;
    w(2500);
    apb(1'b0, freq_prot_pkg::STATUS_OFS, 32'h0);
    chk_reg({30'h0, rd[3:2]}, 32'h3);
    chk_pin(alarm, 1'b0);
    rchk(freq_prot_pkg::FREQ_OFS, 32'h0);
    w(1500);
    apb(1'b0, freq_prot_pkg::STATUS_OFS, 32'h0);
    chk_reg({30'h0, rd[3:2]}, 32'h1);
    w(2000);
    apb(1'b0, freq_prot_pkg::STATUS_OFS, 32'h0);
    chk_reg({30'h0, rd[3:2]}, 32'h0);
    chk_pin(alarm, 1'b1);
    final_report;
  end
endmodule
